// ---- tio_pkg.sv ----
// constants and field layout of the t1 interrupt and overflow status block
// assumes a 200 MHz system clock and an 8-bit processor data path
package tio_pkg;
  // processor port page and register addresses
  localparam logic [3:0] TIO_PAGE = 4'h4;
  localparam logic [4:0] TIO_ADDR_OVF_IRQ = 5'h1d;
  localparam logic [4:0] TIO_ADDR_LINK_IRQ = 5'h1e;
  localparam logic [4:0] TIO_ADDR_OVF_LATCH = 5'h1f;
  localparam logic [7:0] TIO_REG_RESET = 8'h00;
  localparam logic [7:0] TIO_RD_UNMAPPED = 8'h00;
  // counter wrap points
  localparam logic [7:0] TIO_CNT_MAX = 8'hff;
  localparam logic [7:0] TIO_CNT_ZERO = 8'h00;
  // overflow bit positions, shared by interrupt and latch registers
  localparam int TIO_OVF_FRAMING = 7;
  localparam int TIO_OVF_CRC6 = 6;
  localparam int TIO_OVF_OOF = 5;
  localparam int TIO_OVF_ALIGN = 4;
  localparam int TIO_OVF_BIPOLAR = 3;
  localparam int TIO_OVF_PRBS = 2;
  localparam int TIO_OVF_PRBS_MF = 1;
  localparam int TIO_OVF_MF_UNSYNC = 0;
  localparam int TIO_NUM_CNT = 8;
  // link event bit positions, bit 7 unused
  localparam int TIO_LNK_DL_A = 6;
  localparam int TIO_LNK_DL_B = 5;
  localparam int TIO_LNK_LOOP = 4;
  localparam int TIO_LNK_ONE_SEC = 3;
  localparam int TIO_LNK_FIVE_SEC = 2;
  localparam int TIO_LNK_BOM = 1;
  localparam int TIO_LNK_SIG = 0;
  // loop code persistence time
  localparam int TIO_CLK_FREQ_KHZ = 200_000;
  localparam int TIO_LOOP_HOLD_MS = 48;
  localparam int TIO_LOOP_W = 24;
  localparam logic [TIO_LOOP_W-1:0] TIO_LOOP_HOLD_CYC =
    TIO_LOOP_W'(TIO_LOOP_HOLD_MS * TIO_CLK_FREQ_KHZ);
  // bit oriented message frame 111111110xxxxxx0, first bit in msb
  localparam logic [15:0] TIO_BOM_MASK = 16'hff81;
  localparam logic [15:0] TIO_BOM_MATCH = 16'hff00;
  localparam int TIO_BOM_CODE_LSB = 1;
  localparam int TIO_BOM_CODE_W = 6;
  localparam int TIO_BOM_HIST = 10;
  localparam int TIO_BOM_MIN = 8;
endpackage

// ---- tio_wrap_detect.sv ----
// wrap detector for one 8-bit event counter
// assumes the counter runs on the same clock and moves at most one step per cycle
module tio_wrap_detect (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_cnt,
  output logic o_wrap
);
  import tio_pkg::*;
  typedef struct packed {
    logic [7:0] prev;
  } tio_wrap_state_t;
  tio_wrap_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.prev = i_cnt;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // reset value of zero keeps a false wrap away after reset
  assign o_wrap = (s_q.prev == TIO_CNT_MAX) && (i_cnt == TIO_CNT_ZERO);
endmodule

// ---- tio_bom_detect.sv ----
// bit oriented message receiver on the facility data link
// assumes one data link bit per i_fdl_bit_valid pulse, first bit first
module tio_bom_detect (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_fdl_bit,
  input wire logic i_fdl_bit_valid,
  output logic o_new_msg
);
  import tio_pkg::*;
  typedef struct packed {
    logic [15:0] shreg;
    logic [TIO_BOM_HIST-1:0][TIO_BOM_CODE_W-1:0] hist;
    logic [TIO_BOM_HIST-1:0] hist_vld;
    logic [TIO_BOM_CODE_W-1:0] accepted;
    logic acc_vld;
    logic new_msg;
  } tio_bom_state_t;
  tio_bom_state_t s_q, s_d;
  always_comb begin
    logic [TIO_BOM_CODE_W-1:0] code;
    int hits;
    code = '0;
    hits = 0;
    s_d = s_q;
    s_d.new_msg = 1'b0;
    if (i_fdl_bit_valid) begin
      s_d.shreg = {s_q.shreg[14:0], i_fdl_bit};
      if ((s_d.shreg & TIO_BOM_MASK) == TIO_BOM_MATCH) begin
        code = s_d.shreg[TIO_BOM_CODE_LSB +: TIO_BOM_CODE_W];
        s_d.shreg = '0;
        s_d.hist = {s_q.hist[TIO_BOM_HIST-2:0], code};
        s_d.hist_vld = {s_q.hist_vld[TIO_BOM_HIST-2:0], 1'b1};
        for (int i = 0; i < TIO_BOM_HIST; i++) begin
          if (s_d.hist_vld[i] && (s_d.hist[i] == code)) begin
            hits = hits + 1;
          end
        end
        if ((hits >= TIO_BOM_MIN) && (!s_q.acc_vld || (code != s_q.accepted))) begin
          s_d.accepted = code;
          s_d.acc_vld = 1'b1;
          s_d.new_msg = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_new_msg = s_q.new_msg;
endmodule

// ---- tio_status.sv ----
// t1 interrupt and overflow status: three read-clear registers on page 4
// assumes all event inputs and the processor read strobe are on i_clk_sys
module tio_status #(
  parameter logic [tio_pkg::TIO_LOOP_W-1:0] LOOP_HOLD_CYCLES = tio_pkg::TIO_LOOP_HOLD_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cpu_rd,
  input wire logic [3:0] i_cpu_page,
  input wire logic [4:0] i_cpu_addr,
  output logic [7:0] o_cpu_rd_data,
  output logic o_cpu_rd_valid,
  input wire logic [7:0] i_framing_err_cnt,
  input wire logic [7:0] i_crc6_err_cnt,
  input wire logic [7:0] i_out_of_frame_cnt,
  input wire logic [7:0] i_align_change_cnt,
  input wire logic [7:0] i_bipolar_viol_cnt,
  input wire logic [7:0] i_prbs_err_cnt,
  input wire logic [7:0] i_prbs_multiframe_cnt,
  input wire logic [7:0] i_multiframe_unsync_cnt,
  input wire logic [7:0] i_ovf_irq_mask,
  input wire logic [7:0] i_link_irq_mask,
  input wire logic i_datalink_ctrl_a_evt,
  input wire logic i_datalink_ctrl_b_evt,
  input wire logic i_loop_code_present,
  input wire logic i_one_second_flag,
  input wire logic i_five_second_flag,
  input wire logic [3:0] i_sig_abcd,
  input wire logic [3:0] i_sig_abcd_debounced,
  input wire logic i_signaling_debounce_en,
  input wire logic i_fdl_bit,
  input wire logic i_fdl_bit_valid,
  output logic [7:0] o_counter_overflow_interrupts,
  output logic [7:0] o_link_event_interrupts,
  output logic [7:0] o_counter_overflow_latches
);
  import tio_pkg::*;

  typedef struct packed {
    logic [7:0] ovf_irq;
    logic [7:0] link_irq;
    logic [7:0] ovf_latch;
    logic [7:0] rd_data;
    logic rd_valid;
    logic one_sec_prev;
    logic five_sec_prev;
    logic [3:0] sig_prev;
    logic [TIO_LOOP_W-1:0] loop_cnt;
    logic loop_done;
  } tio_state_t;

  tio_state_t s_q, s_d;

  logic [TIO_NUM_CNT-1:0][7:0] cnt_vec;
  logic [TIO_NUM_CNT-1:0] wrap;
  logic [7:0] ovf_set;
  logic [7:0] link_evt;
  logic [7:0] link_set;
  logic rd_hit;
  logic rd_ovf;
  logic rd_link;
  logic rd_latch;
  logic loop_fire;
  logic bom_new;
  logic [3:0] sig_sel;
  logic sig_change;

  // counters placed at their overflow bit positions
  always_comb begin
    cnt_vec = '0;
    cnt_vec[TIO_OVF_FRAMING] = i_framing_err_cnt;
    cnt_vec[TIO_OVF_CRC6] = i_crc6_err_cnt;
    cnt_vec[TIO_OVF_OOF] = i_out_of_frame_cnt;
    cnt_vec[TIO_OVF_ALIGN] = i_align_change_cnt;
    cnt_vec[TIO_OVF_BIPOLAR] = i_bipolar_viol_cnt;
    cnt_vec[TIO_OVF_PRBS] = i_prbs_err_cnt;
    cnt_vec[TIO_OVF_PRBS_MF] = i_prbs_multiframe_cnt;
    cnt_vec[TIO_OVF_MF_UNSYNC] = i_multiframe_unsync_cnt;
  end

  for (genvar g = 0; g < TIO_NUM_CNT; g++) begin : g_wrap
    tio_wrap_detect u_wrap (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_cnt(cnt_vec[g]),
      .o_wrap(wrap[g])
    );
  end

  tio_bom_detect u_bom (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_fdl_bit(i_fdl_bit),
    .i_fdl_bit_valid(i_fdl_bit_valid),
    .o_new_msg(bom_new)
  );

  assign ovf_set = wrap & i_ovf_irq_mask;

  assign sig_sel = i_signaling_debounce_en ? i_sig_abcd_debounced : i_sig_abcd;
  assign sig_change = sig_sel != s_q.sig_prev;

  assign loop_fire = i_loop_code_present && !s_q.loop_done &&
                     (s_q.loop_cnt == LOOP_HOLD_CYCLES - 1'b1);

  always_comb begin
    link_evt = '0;
    link_evt[TIO_LNK_DL_A] = i_datalink_ctrl_a_evt;
    link_evt[TIO_LNK_DL_B] = i_datalink_ctrl_b_evt;
    link_evt[TIO_LNK_LOOP] = loop_fire;
    link_evt[TIO_LNK_ONE_SEC] = i_one_second_flag && !s_q.one_sec_prev;
    link_evt[TIO_LNK_FIVE_SEC] = i_five_second_flag && !s_q.five_sec_prev;
    link_evt[TIO_LNK_BOM] = bom_new;
    link_evt[TIO_LNK_SIG] = sig_change;
  end

  assign link_set = link_evt & i_link_irq_mask;

  assign rd_hit = i_cpu_rd && (i_cpu_page == TIO_PAGE);
  assign rd_ovf = rd_hit && (i_cpu_addr == TIO_ADDR_OVF_IRQ);
  assign rd_link = rd_hit && (i_cpu_addr == TIO_ADDR_LINK_IRQ);
  assign rd_latch = rd_hit && (i_cpu_addr == TIO_ADDR_OVF_LATCH);

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = rd_hit;
    s_d.rd_data = s_q.rd_data;
    if (rd_ovf) begin
      s_d.rd_data = s_q.ovf_irq;
    end else if (rd_link) begin
      s_d.rd_data = s_q.link_irq;
    end else if (rd_latch) begin
      s_d.rd_data = s_q.ovf_latch;
    end else if (rd_hit) begin
      s_d.rd_data = TIO_RD_UNMAPPED;
    end
    s_d.ovf_irq = (rd_ovf ? TIO_REG_RESET : s_q.ovf_irq) | ovf_set;
    s_d.link_irq = (rd_link ? TIO_REG_RESET : s_q.link_irq) | link_set;
    s_d.ovf_latch = (rd_latch ? TIO_REG_RESET : s_q.ovf_latch) | wrap;
    s_d.one_sec_prev = i_one_second_flag;
    s_d.five_sec_prev = i_five_second_flag;
    s_d.sig_prev = sig_sel;
    if (!i_loop_code_present) begin
      s_d.loop_cnt = '0;
      s_d.loop_done = 1'b0;
    end else if (loop_fire) begin
      s_d.loop_done = 1'b1;
    end else if (!s_q.loop_done) begin
      s_d.loop_cnt = s_q.loop_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_cpu_rd_data = s_q.rd_data;
  assign o_cpu_rd_valid = s_q.rd_valid;
  assign o_counter_overflow_interrupts = s_q.ovf_irq;
  assign o_link_event_interrupts = s_q.link_irq;
  assign o_counter_overflow_latches = s_q.ovf_latch;

  // checks on the status registers
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  property p_ovf_set;
    (ovf_set != '0) |=> ((o_counter_overflow_interrupts & $past(ovf_set)) == $past(ovf_set));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow irq not set");

  property p_mask_hold;
    ##1 ((o_counter_overflow_interrupts & ~$past(o_counter_overflow_interrupts)
          & ~$past(i_ovf_irq_mask)) == '0);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masked overflow bit set");

  property p_read_clear;
    (rd_ovf && (ovf_set == '0)) |=> (o_counter_overflow_interrupts == TIO_REG_RESET);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_read_data;
    rd_link |=> o_cpu_rd_valid && (o_cpu_rd_data == $past(o_link_event_interrupts));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data mismatch");

  property p_latch_set;
    (wrap != '0) |=> ((o_counter_overflow_latches & $past(wrap)) == $past(wrap));
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_one_sec;
    ($rose(i_one_second_flag) && i_link_irq_mask[TIO_LNK_ONE_SEC])
      |=> o_link_event_interrupts[TIO_LNK_ONE_SEC];
  endproperty
  a_one_sec: assert property (p_one_sec) else $error("one second bit missed");

  property p_set_wins;
    (rd_link && (link_set != '0)) |=> (o_link_event_interrupts == $past(link_set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost on read");

  property p_loop_set;
    (loop_fire && i_link_irq_mask[TIO_LNK_LOOP]) |=> o_link_event_interrupts[TIO_LNK_LOOP];
  endproperty
  a_loop_set: assert property (p_loop_set) else $error("loop code bit missed");

  property p_loop_once;
    loop_fire |=> (!loop_fire) [*2];
  endproperty
  a_loop_once: assert property (p_loop_once) else $error("loop code fired twice");

  property p_bom_set;
    (bom_new && i_link_irq_mask[TIO_LNK_BOM]) |=> o_link_event_interrupts[TIO_LNK_BOM];
  endproperty
  a_bom_set: assert property (p_bom_set) else $error("message bit missed");

  property p_sig_set;
    (sig_change && i_link_irq_mask[TIO_LNK_SIG]) |=> o_link_event_interrupts[TIO_LNK_SIG];
  endproperty
  a_sig_set: assert property (p_sig_set) else $error("signaling bit missed");

  property p_valid_pulse;
    o_cpu_rd_valid |-> $past(rd_hit);
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("stray read valid");

  property p_link_mask_hold;
    ##1 ((o_link_event_interrupts & ~$past(o_link_event_interrupts)
          & ~$past(i_link_irq_mask)) == '0);
  endproperty
  a_link_mask_hold: assert property (p_link_mask_hold) else $error("masked link set");

  property p_read_data_ovf;
    rd_ovf |=> o_cpu_rd_valid && (o_cpu_rd_data == $past(o_counter_overflow_interrupts));
  endproperty
  a_read_data_ovf: assert property (p_read_data_ovf) else $error("overflow read data");

  property p_read_data_latch;
    rd_latch |=> o_cpu_rd_valid && (o_cpu_rd_data == $past(o_counter_overflow_latches));
  endproperty
  a_read_data_latch: assert property (p_read_data_latch) else $error("latch read data");

  property p_link_read_clear;
    (rd_link && (link_set == '0)) |=> (o_link_event_interrupts == TIO_REG_RESET);
  endproperty
  a_link_read_clear: assert property (p_link_read_clear) else $error("link not cleared");

  property p_latch_read_clear;
    (rd_latch && (wrap == '0)) |=> (o_counter_overflow_latches == TIO_REG_RESET);
  endproperty
  a_latch_read_clear: assert property (p_latch_read_clear) else $error("latch not cleared");

  property p_latch_set_wins;
    (rd_latch && (wrap != '0)) |=> (o_counter_overflow_latches == $past(wrap));
  endproperty
  a_latch_set_wins: assert property (p_latch_set_wins) else $error("latch set lost");

  property p_ovf_set_wins;
    (rd_ovf && (ovf_set != '0)) |=> (o_counter_overflow_interrupts == $past(ovf_set));
  endproperty
  a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("overflow set lost");

  property p_five_sec;
    ($rose(i_five_second_flag) && i_link_irq_mask[TIO_LNK_FIVE_SEC])
      |=> o_link_event_interrupts[TIO_LNK_FIVE_SEC];
  endproperty
  a_five_sec: assert property (p_five_sec) else $error("five second bit missed");

  property p_dl_a;
    (i_datalink_ctrl_a_evt && i_link_irq_mask[TIO_LNK_DL_A]) |=> o_link_event_interrupts[TIO_LNK_DL_A];
  endproperty
  a_dl_a: assert property (p_dl_a) else $error("link controller a bit missed");

  property p_dl_b;
    (i_datalink_ctrl_b_evt && i_link_irq_mask[TIO_LNK_DL_B]) |=> o_link_event_interrupts[TIO_LNK_DL_B];
  endproperty
  a_dl_b: assert property (p_dl_b) else $error("link controller b bit missed");

  property p_ovf_hold;
    (!rd_hit && (ovf_set == '0)) |=> $stable(o_counter_overflow_interrupts);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow word changed");

  property p_unmapped;
    (rd_hit && !rd_ovf && !rd_link && !rd_latch) |=> (o_cpu_rd_data == TIO_RD_UNMAPPED);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");

  property p_other_page;
    (i_cpu_rd && (i_cpu_page != TIO_PAGE)) |=> !o_cpu_rd_valid;
  endproperty
  a_other_page: assert property (p_other_page) else $error("other page answered");

  c_read_clear: cover property (rd_ovf && (o_counter_overflow_interrupts != '0) ##1 1'b1);
  c_loop_fire: cover property (loop_fire);
  c_bom_new: cover property (bom_new);
  c_set_wins: cover property (rd_link && (link_set != '0));
endmodule

// ---- t1_interrupt_overflow_status_tb.sv ----
// self-checking bench for the t1 interrupt and overflow status block
// assumes tio_pkg and the tio_status design files are compiled first
module t1_interrupt_overflow_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tio_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic [3:0] page = 4'h0;
  logic [4:0] addr = 5'h00;
  logic [7:0] rdata, ovf, lnk, lat;
  logic rvalid;
  logic [7:0] cnt [8];
  logic [7:0] omask = 8'h00;
  logic [7:0] lmask = 8'h00;
  logic dla = 1'b0, dlb = 1'b0, loopp = 1'b0, one_s = 1'b0, five_s = 1'b0;
  logic [3:0] sig = 4'h0, sigd = 4'h0;
  logic signaling_debounce_en = 1'b0, fbit = 1'b0, fval = 1'b0;
  int n_mismatch = 0;
  int compares = 0;

  initial for (int i = 0; i < 8; i++) cnt[i] = 8'h00;
  always #2.5 clk = ~clk;

  tio_status #(.LOOP_HOLD_CYCLES(24'h00_0010)) DUT (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_cpu_rd(rd), .i_cpu_page(page),
    .i_cpu_addr(addr), .o_cpu_rd_data(rdata), .o_cpu_rd_valid(rvalid),
    .i_framing_err_cnt(cnt[7]), .i_crc6_err_cnt(cnt[6]), .i_out_of_frame_cnt(cnt[5]),
    .i_align_change_cnt(cnt[4]), .i_bipolar_viol_cnt(cnt[3]), .i_prbs_err_cnt(cnt[2]),
    .i_prbs_multiframe_cnt(cnt[1]), .i_multiframe_unsync_cnt(cnt[0]),
    .i_ovf_irq_mask(omask), .i_link_irq_mask(lmask),
    .i_datalink_ctrl_a_evt(dla), .i_datalink_ctrl_b_evt(dlb),
    .i_loop_code_present(loopp), .i_one_second_flag(one_s), .i_five_second_flag(five_s),
    .i_sig_abcd(sig), .i_sig_abcd_debounced(sigd), .i_signaling_debounce_en(signaling_debounce_en),
    .i_fdl_bit(fbit), .i_fdl_bit_valid(fval),
    .o_counter_overflow_interrupts(ovf), .o_link_event_interrupts(lnk),
    .o_counter_overflow_latches(lat)
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // one read strobe; answer is looked at in the cycle after it
  task automatic rdreg(input logic [3:0] pg, input logic [4:0] a, input logic expv,
                       input logic [7:0] exp);
    cyc(1);
    rd = 1'b1;
    page = pg;
    addr = a;
    cyc(1);
    rd = 1'b0;
    chk("read valid", {7'h00, expv}, {7'h00, rvalid});
    if (expv) chk("read data", exp, rdata);
  endtask

  task automatic wrap(input int b);
    cyc(1);
    cnt[b] = TIO_CNT_MAX;
    cyc(1);
    cnt[b] = TIO_CNT_ZERO;
    cyc(3);
  endtask

  task automatic t_ovf();
    for (int b = 0; b < TIO_NUM_CNT; b++) begin
      omask = 8'h00;
      wrap(b);
      chk("masked overflow irq", 8'h00, ovf);
      chk("latch ignores mask", 8'h01 << b, lat);
      omask = 8'h01 << b;
      wrap(b);
      chk("overflow irq", 8'h01 << b, ovf);
      rdreg(TIO_PAGE, TIO_ADDR_OVF_IRQ, 1'b1, 8'h01 << b);
      rdreg(TIO_PAGE, TIO_ADDR_OVF_LATCH, 1'b1, 8'h01 << b);
      chk("overflow irq cleared", 8'h00, ovf);
      chk("latch cleared", 8'h00, lat);
    end
    $display("test overflow done");
  endtask

  task automatic pulse_src(input int k);
    cyc(1);
    case (k)
      TIO_LNK_DL_A: dla = 1'b1;
      TIO_LNK_DL_B: dlb = 1'b1;
      TIO_LNK_ONE_SEC: one_s = 1'b1;
      TIO_LNK_FIVE_SEC: five_s = 1'b1;
      default: sig = sig ^ 4'h1;
    endcase
    cyc(1);
    dla = 1'b0;
    dlb = 1'b0;
    one_s = 1'b0;
    five_s = 1'b0;
    cyc(3);
  endtask

  task automatic t_link();
    int srcs [5] = '{TIO_LNK_DL_A, TIO_LNK_DL_B, TIO_LNK_ONE_SEC, TIO_LNK_FIVE_SEC, TIO_LNK_SIG};
    foreach (srcs[i]) begin
      lmask = 8'h00;
      pulse_src(srcs[i]);
      chk("masked link irq", 8'h00, lnk);
      lmask = 8'hff;
      pulse_src(srcs[i]);
      chk("link irq", 8'h01 << srcs[i], lnk);
      rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h01 << srcs[i]);
      chk("link irq cleared", 8'h00, lnk);
    end
    $display("test link events done");
  endtask

  task automatic t_debounce();
    sigd = sig;
    cyc(1);
    signaling_debounce_en = 1'b1;
    cyc(3);
    rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h00);
    sig = sig ^ 4'h2;
    cyc(3);
    chk("raw change ignored", 8'h00, lnk);
    sigd = sigd ^ 4'h4;
    cyc(3);
    chk("debounced change", 8'h01, lnk);
    rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h01);
    $display("test debounce done");
  endtask

  task automatic t_loop();
    loopp = 1'b1;
    cyc(10);
    loopp = 1'b0;
    cyc(3);
    chk("short loop code", 8'h00, lnk);
    loopp = 1'b1;
    cyc(20);
    chk("loop code held", 8'h10, lnk);
    rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h10);
    cyc(10);
    chk("no refire while held", 8'h00, lnk);
    loopp = 1'b0;
    $display("test loop code done");
  endtask

  task automatic send_msg(input logic [5:0] code, input int n);
    logic [15:0] f;
    f = TIO_BOM_MATCH | {9'h000, code, 1'b0};
    repeat (n) begin
      for (int i = 15; i >= 0; i--) begin
        cyc(1);
        fbit = f[i];
        fval = 1'b1;
        cyc(1);
        fval = 1'b0;
      end
    end
    cyc(4);
  endtask

  task automatic t_bom();
    send_msg(6'h2a, 7);
    chk("seven of ten", 8'h00, lnk);
    send_msg(6'h2a, 1);
    chk("eight of ten", 8'h02, lnk);
    rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h02);
    send_msg(6'h2a, 2);
    chk("same message again", 8'h00, lnk);
    $display("test message done");
  endtask

  task automatic t_prio();
    cyc(1);
    rd = 1'b1;
    page = TIO_PAGE;
    addr = TIO_ADDR_LINK_IRQ;
    dla = 1'b1;
    cyc(1);
    rd = 1'b0;
    dla = 1'b0;
    chk("pre-read data", 8'h00, rdata);
    chk("set wins over clear", 8'h40, lnk);
    rdreg(4'h3, TIO_ADDR_LINK_IRQ, 1'b0, 8'h00);
    chk("other page no clear", 8'h40, lnk);
    rdreg(TIO_PAGE, 5'h00, 1'b1, TIO_RD_UNMAPPED);
    rdreg(TIO_PAGE, TIO_ADDR_LINK_IRQ, 1'b1, 8'h40);
    $display("test priority done");
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("reset 1d", TIO_REG_RESET, ovf);
    chk("reset 1e", TIO_REG_RESET, lnk);
    chk("reset 1f", TIO_REG_RESET, lat);
    t_ovf();
    t_link();
    t_debounce();
    t_loop();
    t_bom();
    t_prio();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule
